// >>> hw/adc_ctrl_pkg.sv
// Purpose: Shared constants for the converter conversion control block
// Assumes: 8-bit special function register port, 10 MHz master clock
// Notes:   Result register offsets and the busy register are fixed here
package adc_ctrl_pkg;

  // Register offsets on the special function register port
  localparam logic [7:0] MODE_CHAN_ADDR   = 8'hd8;
  localparam logic [7:0] TIMING_ADDR      = 8'hef;
  localparam logic [7:0] CAL_CTRL_ADDR    = 8'hf5;
  localparam logic [7:0] RESULT_LOW_ADDR  = 8'hd9;
  localparam logic [7:0] RESULT_HIGH_ADDR = 8'hda;

  // Reset values
  localparam logic [7:0] MODE_CHAN_RESET  = 8'h00;
  localparam logic [7:0] TIMING_RESET     = 8'h00;

  // Timing and trigger register fields
  localparam int POWER_BIT   = 7;
  localparam int REF_BIT     = 6;
  localparam int DIV_HI_BIT  = 5;
  localparam int DIV_LO_BIT  = 4;
  localparam int ACQ_HI_BIT  = 3;
  localparam int ACQ_LO_BIT  = 2;
  localparam int TIMER_BIT   = 1;
  localparam int PIN_BIT     = 0;

  // Mode and channel register fields, and the busy register bit
  localparam int EOC_BIT     = 7;
  localparam int DMA_BIT     = 6;
  localparam int CONT_BIT    = 5;
  localparam int SINGLE_BIT  = 4;
  localparam int CHAN_HI_BIT = 3;
  localparam int BUSY_BIT    = 7;

  // Converter clock divide ratios by code
  localparam logic [4:0] DIV_RATIO_00 = 5'h10;
  localparam logic [4:0] DIV_RATIO_01 = 5'h02;
  localparam logic [4:0] DIV_RATIO_10 = 5'h04;
  localparam logic [4:0] DIV_RATIO_11 = 5'h08;

  // Conversion length in converter clocks, and channel codes
  localparam logic [4:0] CONV_CLKS     = 5'h11;
  localparam logic [3:0] DMA_STOP_CODE = 4'hf;
  localparam logic [3:0] CHAN_TEMP     = 4'h8;
  localparam logic [3:0] CHAN_DAC_A    = 4'h9;
  localparam logic [3:0] CHAN_DAC_B    = 4'ha;
  localparam logic [3:0] CHAN_ANALOG_GROUND     = 4'hb;
  localparam logic [3:0] CHAN_VREF     = 4'hc;

  // External start pulse minimum width, met by the two-stage synchroniser
  localparam int MCLK_PERIOD_NS  = 100;
  localparam int PIN_MIN_NS      = 100;
  localparam int PIN_MIN_CYCLES  =
    (PIN_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  // DMA address width for the 16 MByte space
  localparam int DMA_ADDR_W = 24;

endpackage : adc_ctrl_pkg

// >>> hw/conv_clock_if.sv
// Purpose: Carries divider setting and converter clock between modules
// Assumes: Single master clock domain
// Notes:   Tick marks the last master cycle of each converter clock
`timescale 1ns/1ps
interface conv_clock_if;
  logic [1:0] div_code;
  logic       tick;
  logic       clk_level;

  modport source (input div_code, output tick, output clk_level);
  modport sink   (output div_code, input tick, input clk_level);
endinterface : conv_clock_if

// >>> hw/conv_clock_div.sv
// Purpose: Divides the master clock into the converter clock
// Assumes: Divider code may change at any time; new ratio applies to the period in progress
// Notes:   clk_level is high for half of each period, starting at the second master cycle of the period
`timescale 1ns/1ps
module conv_clock_div (
  // Clock and reset
  input  wire logic      clk_in,
  input  wire logic      rst_n_in,
  // Divider link
  conv_clock_if.source   div_if
);
  import adc_ctrl_pkg::*;

  logic [4:0] count;
  logic [4:0] ratio;

  always_comb begin
    unique case (div_if.div_code)
      2'b00: ratio = DIV_RATIO_00;
      2'b01: ratio = DIV_RATIO_01;
      2'b10: ratio = DIV_RATIO_10;
      2'b11: ratio = DIV_RATIO_11;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count        <= 5'h00;
      div_if.tick  <= 1'b0;
    end else begin
      // Equality keeps the tick to one master cycle per period
      div_if.tick <= (count == ratio - 5'h02);
      if (count >= ratio - 5'h01) begin
        count <= 5'h00;
      end else begin
        count <= count + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      div_if.clk_level <= 1'b0;
    end else begin
      div_if.clk_level <= (count < (ratio >> 1));
    end
  end

endmodule : conv_clock_div

// >>> hw/sar_adc_conversion_control.sv
// Purpose: Conversion control for an 8-channel 12-bit SAR converter
// Assumes: Special function register port on the master clock
// Notes:   DMA table lives in external memory, 2 bytes per entry
//
// Overview of operation
// [RQ1] Result is 12-bit straight binary, LSB FS/4096
// [RQ2] Result high/low registers, channel in top nibble
// [RQ3] Power bit 7 powers converter up or down
// [RQ4] Bit 6 selects external or internal reference
// [RQ5] Divide codes 00,01,10,11 give 16,2,4,8
// [RQ6] Conversion takes 17 converter clocks after track
// [RQ7] Software keeps converter clock at 4.5 MHz max
// [RQ8] Acquire codes give 1 to 4 converter clocks
// [RQ9] Bit 1 lets timer overflow start conversions
// [RQ10] Bit 0 lets low start pin start conversions
// [RQ11] Start pin pulses low longer than 100 ns
// [RQ12] Flag bit 7 set at single or DMA end
// [RQ13] Flag cleared on vector or by software
// [RQ14] DMA bit 6 starts capture, self-clears at end
// [RQ15] Address latch strobe stops until DMA starts
// [RQ16] Continuous bit 5 restarts after each conversion
// [RQ17] Single bit 4 starts one, clears when done; stays set if continuous bit 5 was set when that conversion started
// [RQ18] Channel bits sampled when conversion starts
// [RQ19] Channel codes: inputs, monitor, DACs, ground, reference
// [RQ20] DMA channel comes from external memory entry
// [RQ21] Temperature channel needs 1 us acquisition
// [RQ22] DMA fills up to 16 MByte unattended
// [RQ23] Busy bit read-only, set while converting
// [RQ24] Channel code 1111 ends DMA sequence
`timescale 1ns/1ps
module sar_adc_conversion_control #(
  parameter logic [23:0] DMA_BASE = 24'h000000
) (
  // Clock and reset
  input  wire logic                            clk_in,
  input  wire logic                            rst_n_in,
  // Special function register port
  input  wire logic [7:0]                      sfr_addr_in,
  input  wire logic                            sfr_wr_in,
  input  wire logic [7:0]                      sfr_wdata_in,
  output logic [7:0]                           sfr_rdata_out,
  // Trigger sources and interrupt vector acknowledge
  input  wire logic                            timer_overflow_in,
  input  wire logic                            conversion_start_pin_n_in,
  input  wire logic                            isr_vector_ack_in,
  // Converter core
  output logic                                 converter_power_on_out,
  output logic                                 outside_reference_select_out,
  output logic                                 conv_clk_out,
  output logic [3:0]                           channel_out,
  output logic                                 track_out,
  output logic                                 convert_out,
  input  wire logic [11:0]                     sar_result_in,
  // External data memory for DMA
  output logic [adc_ctrl_pkg::DMA_ADDR_W-1:0]  dma_addr_out,
  output logic                                 dma_rd_req_out,
  input  wire logic                            dma_rd_ack_in,
  input  wire logic [7:0]                      dma_rdata_in,
  output logic                                 dma_wr_req_out,
  output logic [7:0]                           dma_wdata_out,
  input  wire logic                            dma_wr_ack_in,
  // Address latch strobe gate
  output logic                                 ale_enable_out
);
  import adc_ctrl_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ACQ, ST_CONV, ST_FETCH, ST_WR_HI, ST_WR_LO
  } state_t;

  state_t      state;
  logic [7:0]  timing_reg;
  logic        end_of_conversion_flag;
  logic        dma_run;
  logic        continuous_run;
  logic        one_shot_run;
  logic [3:0]  channel_sel;
  logic [11:0] result;
  logic [3:0]  result_chan;
  logic [3:0]  cur_chan;
  logic [4:0]  tick_count;
  logic        in_dma;
  logic        pin_sync_a;
  logic        pin_sync_b;
  logic        pin_prev;
  logic        trig_pending;
  logic        single_active;
  logic        wr_mode;
  logic        wr_timing;
  logic        powered;
  logic        conv_last;
  logic        acq_last;
  logic [4:0]  acq_clks;
  logic        start_normal;
  logic        start_dma;
  logic        set_eoc;
  logic        dma_done;

  conv_clock_if div_link ();

  conv_clock_div u_div (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .div_if   (div_link.source)
  );

  assign div_link.div_code = timing_reg[DIV_HI_BIT:DIV_LO_BIT]; // [RQ5]

  assign wr_mode   = sfr_wr_in && (sfr_addr_in == MODE_CHAN_ADDR);
  assign wr_timing = sfr_wr_in && (sfr_addr_in == TIMING_ADDR);
  assign powered   = timing_reg[POWER_BIT];
  assign acq_clks  = {3'b000, timing_reg[ACQ_HI_BIT:ACQ_LO_BIT]} + 5'h01;
  // First tick only aligns, so track never ends before a full clock
  assign acq_last  = div_link.tick && (tick_count == acq_clks);
  assign conv_last = div_link.tick && (tick_count == CONV_CLKS - 5'h01);

  // Timing and trigger register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      timing_reg <= TIMING_RESET;
    end else if (wr_timing) begin
      timing_reg <= sfr_wdata_in;
    end
  end

  // Converter static controls
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      converter_power_on_out       <= 1'b0;
      outside_reference_select_out <= 1'b0;
      conv_clk_out                 <= 1'b0;
    end else begin
      converter_power_on_out       <= powered; // [RQ3]
      outside_reference_select_out <= timing_reg[REF_BIT]; // [RQ4]
      conv_clk_out                 <= div_link.clk_level && powered;
    end
  end

  // Start pin synchroniser; pulses over 100 ns always reach the second stage
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin_sync_a <= 1'b1;
      pin_sync_b <= 1'b1;
      pin_prev   <= 1'b1;
    end else begin
      pin_sync_a <= conversion_start_pin_n_in;
      pin_sync_b <= pin_sync_a; // [RQ11]
      pin_prev   <= pin_sync_b;
    end
  end

  // Hardware triggers wait here until the converter is idle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      trig_pending <= 1'b0;
    end else if ((timer_overflow_in && timing_reg[TIMER_BIT]) // [RQ9]
                 || (pin_prev && !pin_sync_b
                     && timing_reg[PIN_BIT])) begin // [RQ10]
      trig_pending <= 1'b1;
    end else if (start_normal) begin
      trig_pending <= 1'b0;
    end
  end

  assign start_normal = (state == ST_IDLE) && powered && !dma_run
                        && (one_shot_run || continuous_run // [RQ16]
                            || trig_pending);
  assign start_dma    = (state == ST_IDLE) && powered && dma_run;
  assign dma_done     = (state == ST_FETCH) && dma_rd_ack_in
                        && (dma_rdata_in[7:4] == DMA_STOP_CODE); // [RQ24]
  assign set_eoc      = (conv_last && (state == ST_CONV) && !in_dma)
                        || dma_done; // [RQ12]

  // Mode and channel register; a hardware set wins over a clear
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      end_of_conversion_flag <= MODE_CHAN_RESET[EOC_BIT];
      dma_run                <= MODE_CHAN_RESET[DMA_BIT];
      continuous_run         <= MODE_CHAN_RESET[CONT_BIT];
      channel_sel            <= MODE_CHAN_RESET[CHAN_HI_BIT:0];
    end else begin
      if (set_eoc) begin
        end_of_conversion_flag <= 1'b1;
      end else if (isr_vector_ack_in) begin
        end_of_conversion_flag <= 1'b0; // [RQ13]
      end else if (wr_mode) begin
        end_of_conversion_flag <= sfr_wdata_in[EOC_BIT]; // [RQ13]
      end
      if (wr_mode) begin
        dma_run        <= sfr_wdata_in[DMA_BIT]; // [RQ14]
        continuous_run <= sfr_wdata_in[CONT_BIT];
        channel_sel    <= sfr_wdata_in[CHAN_HI_BIT:0];
      end else if (dma_done) begin
        dma_run <= 1'b0; // [RQ14]
      end
    end
  end

  // Single conversion bit; a fresh software write beats the completion
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      one_shot_run  <= MODE_CHAN_RESET[SINGLE_BIT];
      single_active <= 1'b0;
    end else begin
      if (wr_mode) begin
        one_shot_run <= sfr_wdata_in[SINGLE_BIT];
      end else if (single_active && conv_last && state == ST_CONV) begin
        one_shot_run <= 1'b0; // [RQ17]
      end
      if (start_normal) begin
        single_active <= one_shot_run && !continuous_run;
      end else if (conv_last && state == ST_CONV) begin
        single_active <= 1'b0;
      end
    end
  end

  // Conversion sequencer
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state      <= ST_IDLE;
      tick_count <= 5'h00;
      cur_chan   <= 4'h0;
      in_dma     <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          tick_count <= 5'h00;
          if (start_dma) begin
            state  <= ST_FETCH;
            in_dma <= 1'b1;
          end else if (start_normal) begin
            state    <= ST_ACQ;
            cur_chan <= channel_sel; // [RQ18]
            in_dma   <= 1'b0;
          end
        end
        ST_ACQ: begin
          if (acq_last) begin
            state      <= ST_CONV; // [RQ8]
            tick_count <= 5'h00;
          end else if (div_link.tick) begin
            tick_count <= tick_count + 5'h01;
          end
        end
        ST_CONV: begin
          if (conv_last) begin
            tick_count <= 5'h00; // [RQ6]
            state      <= in_dma ? ST_WR_HI : ST_IDLE;
          end else if (div_link.tick) begin
            tick_count <= tick_count + 5'h01;
          end
        end
        ST_FETCH: begin
          if (dma_done) begin
            state  <= ST_IDLE;
            in_dma <= 1'b0;
          end else if (dma_rd_ack_in) begin
            state    <= ST_ACQ;
            cur_chan <= dma_rdata_in[7:4]; // [RQ20]
          end
        end
        ST_WR_HI: begin
          if (dma_wr_ack_in) begin
            state <= ST_WR_LO;
          end
        end
        ST_WR_LO: begin
          if (dma_wr_ack_in) begin
            state <= ST_FETCH; // [RQ22]
          end
        end
      endcase
    end
  end

  // Result capture with channel tag
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      result      <= 12'h000;
      result_chan <= 4'h0;
    end else if (state == ST_CONV && conv_last) begin
      result      <= sar_result_in; // [RQ1]
      result_chan <= cur_chan; // [RQ2]
    end
  end

  // DMA memory walk across the 24-bit space
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dma_addr_out   <= DMA_BASE;
      dma_rd_req_out <= 1'b0;
      dma_wr_req_out <= 1'b0;
      dma_wdata_out  <= 8'h00;
    end else begin
      dma_rd_req_out <= (state == ST_FETCH) && !dma_rd_ack_in
                        && !dma_rd_req_out;
      dma_wr_req_out <= 1'b0;
      if (state == ST_IDLE && start_dma) begin
        dma_addr_out <= DMA_BASE;
      end else if (state == ST_CONV && conv_last && in_dma) begin
        dma_wr_req_out <= 1'b1;
        dma_wdata_out  <= {cur_chan, sar_result_in[11:8]};
      end else if (state == ST_WR_HI && dma_wr_ack_in) begin
        dma_addr_out   <= dma_addr_out + 24'h000001;
        dma_wr_req_out <= 1'b1;
        dma_wdata_out  <= result[7:0];
      end else if (state == ST_WR_LO && dma_wr_ack_in) begin
        dma_addr_out <= dma_addr_out + 24'h000001; // [RQ22]
      end
    end
  end

  // Analog front end controls
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      channel_out <= 4'h0;
      track_out   <= 1'b0;
      convert_out <= 1'b0;
    end else begin
      // Codes 8..c route internal sources; a 1111 DMA stop entry never reaches the mux
      channel_out <= cur_chan; // [RQ19]
      track_out   <= (state == ST_ACQ) && !acq_last;
      convert_out <= (state == ST_CONV && !conv_last)
                     || (state == ST_ACQ && acq_last);
    end
  end

  // Strobe halts from DMA request until the sequence actually runs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ale_enable_out <= 1'b1;
    end else begin
      ale_enable_out <= !(dma_run && !in_dma); // [RQ15]
    end
  end

  // Register read; unmapped offsets read zero
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sfr_rdata_out <= 8'h00;
    end else begin
      unique case (sfr_addr_in)
        MODE_CHAN_ADDR:
          sfr_rdata_out <= {end_of_conversion_flag, dma_run,
                            continuous_run, one_shot_run, channel_sel};
        TIMING_ADDR:      sfr_rdata_out <= timing_reg;
        RESULT_HIGH_ADDR: sfr_rdata_out <= {result_chan, result[11:8]};
        RESULT_LOW_ADDR:  sfr_rdata_out <= result[7:0];
        CAL_CTRL_ADDR:    sfr_rdata_out <= {state != ST_IDLE,
                                            7'h00}; // [RQ23]
        default:          sfr_rdata_out <= 8'h00;
      endcase
    end
  end

endmodule : sar_adc_conversion_control

// >>> verif/sar_adc_props.sv
// Purpose: Port assertions for the conversion control block
// Assumes: Divider and acquire codes stay put during a conversion
// Notes:   Phase lengths are judged against the last timing write
`timescale 1ns/1ps
module sar_adc_props
  import adc_ctrl_pkg::*;
(
  // Clock, reset and register port
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic       sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  // Converter core and DMA
  input wire logic       converter_power_on_out,
  input wire logic       outside_reference_select_out,
  input wire logic       conv_clk_out,
  input wire logic [3:0] channel_out,
  input wire logic       track_out,
  input wire logic       convert_out,
  input wire logic       dma_rd_req_out,
  input wire logic       dma_wr_req_out
);
  logic [7:0] tim;
  logic [9:0] trk_n;
  logic [9:0] cnv_n;
  logic [9:0] ratio;
  logic [9:0] acq;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) tim <= TIMING_RESET;
    else if (sfr_wr_in && sfr_addr_in == TIMING_ADDR) tim <= sfr_wdata_in;
  end
  always_ff @(posedge clk_in) begin
    trk_n <= track_out ? trk_n + 10'h001 : 10'h000;
  end
  always_ff @(posedge clk_in) begin
    cnv_n <= convert_out ? cnv_n + 10'h001 : 10'h000;
  end
  always_comb begin
    acq = {8'h00, tim[ACQ_HI_BIT:ACQ_LO_BIT]};
    case (tim[DIV_HI_BIT:DIV_LO_BIT])
      2'b00:   ratio = {5'h00, DIV_RATIO_00};
      2'b01:   ratio = {5'h00, DIV_RATIO_01};
      2'b10:   ratio = {5'h00, DIV_RATIO_10};
      default: ratio = {5'h00, DIV_RATIO_11};
    endcase
  end
  power_follow_a: assert property (sfr_wr_in && sfr_addr_in == TIMING_ADDR
    |-> ##2 converter_power_on_out == tim[POWER_BIT])
    else $error("power output differs from written bit");
  ref_follow_a: assert property (sfr_wr_in && sfr_addr_in == TIMING_ADDR
    |-> ##2 outside_reference_select_out == tim[REF_BIT])
    else $error("reference select differs from written bit");
  clk_idle_a: assert property (!converter_power_on_out
    && !$past(converter_power_on_out) |-> !conv_clk_out)
    else $error("converter clock runs while unpowered");
  phase_excl_a: assert property (!(track_out && convert_out))
    else $error("track and convert high together");
  conv_len_a: assert property ($fell(convert_out)
    |-> cnv_n == CONV_CLKS * ratio)
    else $error("conversion phase length wrong");
  track_len_a: assert property ($fell(track_out)
    |-> trk_n >= (acq + 10'h001) * ratio
        && trk_n <= (acq + 10'h002) * ratio)
    else $error("acquire phase length wrong");
  track_first_a: assert property ($rose(convert_out) |-> $past(track_out))
    else $error("conversion without acquire before it");
  powered_start_a: assert property ($rose(track_out)
    |-> converter_power_on_out)
    else $error("acquire started while unpowered");
  chan_hold_a: assert property (convert_out && $past(convert_out)
    |-> $stable(channel_out))
    else $error("channel moved during conversion");
  rd_pulse_a: assert property (dma_rd_req_out |=> !dma_rd_req_out)
    else $error("read request longer than one cycle");
  wr_pulse_a: assert property (dma_wr_req_out |=> !dma_wr_req_out)
    else $error("write request longer than one cycle");
  cover property ($fell(convert_out));
  cover property ($rose(track_out) && tim[TIMER_BIT]);
  cover property (dma_wr_req_out);
endmodule : sar_adc_props

// >>> verif/conv_core_model.sv
// Purpose: Converter core and external memory seen by the block
// Assumes: Result is a fixed pattern of the selected channel
// Notes:   Idle result and read data lines toggle so a stale value is never mistaken
`timescale 1ns/1ps
module conv_core_model
  import adc_ctrl_pkg::*;
(
  // Clock and slow-answer select
  input  wire logic                           clk_in,
  input  wire logic                           slow_in,
  // Converter core
  input  wire logic [3:0]                     chan_in,
  input  wire logic                           converting_in,
  output logic      [11:0]                    result_out = 12'h000,
  // External data memory
  input  wire logic [adc_ctrl_pkg::DMA_ADDR_W-1:0] addr_in,
  input  wire logic                           rd_req_in,
  output logic                                rd_ack_out = 1'b0,
  output logic      [7:0]                     rdata_out = 8'h00,
  input  wire logic                           wr_req_in,
  input  wire logic [7:0]                     wdata_in,
  output logic                                wr_ack_out = 1'b0
);
  logic [7:0] mem [8] = '{8'h20, 8'h00, 8'h90, 8'h00,
                          8'hf0, 8'h00, 8'h00, 8'h00};
  logic [2:0] rd_wait = 3'h0;
  always @(posedge clk_in) begin
    result_out <= converting_in ? {~chan_in, chan_in, 4'h5} : ~result_out;
    rd_ack_out <= (rd_wait == 3'h1);
    rdata_out  <= (rd_wait == 3'h1) ? mem[addr_in[2:0]] : ~rdata_out;
    if (rd_wait != 3'h0) rd_wait <= rd_wait - 3'h1;
    else if (rd_req_in) rd_wait <= slow_in ? 3'h4 : 3'h1;
    wr_ack_out <= wr_req_in;
    if (wr_req_in) mem[addr_in[2:0]] <= wdata_in;
  end
endmodule : conv_core_model

// >>> verif/sar_adc_conversion_control_bench.sv
// Purpose: Self-checking bench for the conversion control block
// Assumes: Divider code 01 unused, 5 MHz would exceed the limit
// Notes:   Result pattern from the core model is {~ch, ch, 5}
`timescale 1ns/1ps
module sar_adc_conversion_control_bench;
  import adc_ctrl_pkg::*;
  typedef struct packed {logic [7:0] tim; logic [3:0] ch;} row_t;
  logic clk_in = 1'b0, rst_n_in = 1'b0, wr = 1'b0, tmr = 1'b0;
  logic pin_n = 1'b1, isr = 1'b0, slow = 1'b0, ale_gap = 1'b0, p;
  logic [7:0] addr = 8'h00, wdata = 8'h00, r, rdata, rbyte, wbyte;
  logic pwr, rsel, cclk, trk, cnv, rreq, rack, wreq, wack, ale;
  logic [3:0] chan;
  logic [11:0] res;
  logic [23:0] maddr;
  int num_errors = 0, checks_done = 0, cycles = 0, rises;
  row_t rows [7] = '{'{8'ha8, 4'h0}, '{8'he0, 4'h7}, '{8'hbc, 4'h8},
    '{8'h84, 4'h9}, '{8'hac, 4'ha}, '{8'hb8, 4'hb}, '{8'ha8, 4'hc}};
  logic [7:0] dma_exp [5] = '{8'h2d, 8'h25, 8'h96, 8'h95, 8'hf0};
  sar_adc_conversion_control i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_wdata_in(wdata),
    .sfr_rdata_out(rdata), .timer_overflow_in(tmr),
    .conversion_start_pin_n_in(pin_n), .isr_vector_ack_in(isr),
    .converter_power_on_out(pwr), .outside_reference_select_out(rsel),
    .conv_clk_out(cclk), .channel_out(chan), .track_out(trk),
    .convert_out(cnv), .sar_result_in(res), .dma_addr_out(maddr),
    .dma_rd_req_out(rreq), .dma_rd_ack_in(rack), .dma_rdata_in(rbyte),
    .dma_wr_req_out(wreq), .dma_wdata_out(wbyte), .dma_wr_ack_in(wack),
    .ale_enable_out(ale));
  conv_core_model i_core (.clk_in(clk_in), .slow_in(slow),
    .chan_in(chan), .converting_in(cnv), .result_out(res),
    .addr_in(maddr), .rd_req_in(rreq), .rd_ack_out(rack),
    .rdata_out(rbyte), .wr_req_in(wreq), .wdata_in(wbyte),
    .wr_ack_out(wack));
  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (!ale && rst_n_in) ale_gap <= 1'b1;
    if (cycles == 60000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [7:0] e, g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask : chk
  task automatic put(input logic [7:0] a, d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : put
  task automatic get(input logic [7:0] a);
    @(posedge clk_in);
    addr <= a;
    repeat (2) @(posedge clk_in);
    #1 r = rdata;
  endtask : get
  task automatic wait_bits(input logic [7:0] a, m, v);
    for (int i = 0; i < 400; i++) begin
      get(a);
      if ((r & m) == v) break;
    end
    chk("status wait", v, r & m);
  endtask : wait_bits
  task automatic res_chk(input logic [3:0] ch);
    get(RESULT_HIGH_ADDR);
    chk("result high", {ch, ~ch}, r);
    get(RESULT_LOW_ADDR);
    chk("result low", {ch, 4'h5}, r);
  endtask : res_chk
  task automatic strobe(input int which);
    @(posedge clk_in);
    if (which == 0) tmr <= 1'b1; else isr <= 1'b1;
    @(posedge clk_in);
    tmr <= 1'b0;
    isr <= 1'b0;
  endtask : strobe
  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    get(TIMING_ADDR);
    chk("timing reset", TIMING_RESET, r);
    get(MODE_CHAN_ADDR);
    chk("mode reset", MODE_CHAN_RESET, r);
    put(8'he0, 8'hff);
    get(8'he0);
    chk("unmapped", 8'h00, r);
    chk("ale idle", 8'h01, {7'h00, ale});
    foreach (rows[i]) begin
      put(TIMING_ADDR, rows[i].tim);
      put(MODE_CHAN_ADDR, {4'h1, rows[i].ch});
      get(CAL_CTRL_ADDR);
      chk("busy", 8'h80, r);
      chk("power ref", {6'h00, rows[i].tim[7:6]}, {6'h00, pwr, rsel});
      wait_bits(MODE_CHAN_ADDR, 8'h10, 8'h00);
      chk("mode", {4'h8, rows[i].ch}, r);
      res_chk(rows[i].ch);
      strobe(1);
      get(MODE_CHAN_ADDR);
      chk("flag clear", {4'h0, rows[i].ch}, r);
    end
    put(MODE_CHAN_ADDR, 8'h03);
    strobe(0);
    repeat (4) @(posedge clk_in);
    #1 chk("timer off", 8'h00, {7'h00, trk});
    put(TIMING_ADDR, 8'haa);
    strobe(0);
    wait_bits(MODE_CHAN_ADDR, 8'h80, 8'h80);
    res_chk(4'h3);
    put(MODE_CHAN_ADDR, 8'h05);
    put(TIMING_ADDR, 8'ha9);
    @(posedge clk_in);
    pin_n <= 1'b0;
    repeat (2) @(posedge clk_in);
    pin_n <= 1'b1;
    wait_bits(MODE_CHAN_ADDR, 8'h80, 8'h80);
    res_chk(4'h5);
    put(TIMING_ADDR, 8'ha8);
    put(MODE_CHAN_ADDR, 8'h26);
    rises = 0;
    p = 1'b0;
    repeat (300) begin
      @(posedge clk_in);
      #1 if (cnv && !p) rises++;
      p = cnv;
    end
    chk("restarts", 8'h01, {7'h00, rises >= 2});
    put(MODE_CHAN_ADDR, 8'h06);
    wait_bits(CAL_CTRL_ADDR, 8'h80, 8'h00);
    res_chk(4'h6);
    slow <= 1'b1;
    put(MODE_CHAN_ADDR, 8'h40);
    wait_bits(MODE_CHAN_ADDR, 8'h40, 8'h00);
    chk("dma flag", 8'h80, r & 8'h80);
    chk("ale gap", 8'h01, {7'h00, ale_gap});
    chk("ale after", 8'h01, {7'h00, ale});
    foreach (dma_exp[i]) chk("dma byte", dma_exp[i], i_core.mem[i]);
    put(TIMING_ADDR, 8'h00);
    repeat (3) @(posedge clk_in);
    #1 chk("power off", 8'h00, {7'h00, pwr});
    wrap_up();
  end
endmodule : sar_adc_conversion_control_bench
bind sar_adc_conversion_control sar_adc_props i_props (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
  .sfr_wdata_in(sfr_wdata_in), .converter_power_on_out(converter_power_on_out),
  .outside_reference_select_out(outside_reference_select_out),
  .conv_clk_out(conv_clk_out), .channel_out(channel_out),
  .track_out(track_out), .convert_out(convert_out),
  .dma_rd_req_out(dma_rd_req_out), .dma_wr_req_out(dma_wr_req_out));
